// ==== common/sdfb_pkg.sv ====
// Constants and types of the service data forwarding bridge.
// Assumes a single 50 MHz system clock shared by all users.
package sdfb_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CYCLE_MS = 10;
  localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
  // ==========================================================
  // Queue and entry layout
  localparam int unsigned FIFO_DEPTH = 50;
  localparam int unsigned INDEX_W = 16;
  localparam int unsigned SUB_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ENTRY_W = INDEX_W + SUB_W + DATA_W;
  localparam int unsigned LOCAL_DEPTH = 64;
  // ==========================================================
  // Object indices with special actions
  localparam logic [15:0] IDX_SAVE = 16'h1010;
  localparam logic [15:0] IDX_RESTORE_BLOCK = 16'h1011;
  localparam logic [15:0] IDX_RESTORE_BYTE = 16'h2015;
  // ==========================================================
  // Reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  // ==========================================================
  // Exchange slot states
  typedef enum logic [3:0] {
    SL_IDLE = 4'h1,
    SL_PD = 4'h2,
    SL_GAP = 4'h4,
    SL_SD = 4'h8
  } sdfb_slot_t;
endpackage : sdfb_pkg

// ==== rtl/sdfb_bridge.sv ====
// Service data forwarding bridge between the fieldbus side and the main controller.
// Assumes bus requests and link signals come from logic on i_clk.
// How it works
// - Byte-store parameters committed right after each accepted write
// - Block-store parameters staged in RAM until save
// - Power loss restores block store from last save
// - Two restore commands, byte and block store
// - Link exchanges on a fixed ten millisecond cycle
// - At most one queued command per gap
// - Commands accepted anytime the queue has room, values kept locally
// - Reads answered locally without waiting
// - Writes queued in fifty-entry ring, in order
// - Objects addressed by sixteen-bit index
`timescale 1ns/100ps
module sdfb_bridge #(
  parameter int unsigned CYCLE_CLKS = sdfb_pkg::CYCLE_CLKS,
  parameter int unsigned FIFO_DEPTH = sdfb_pkg::FIFO_DEPTH,
  parameter int unsigned LOCAL_DEPTH = sdfb_pkg::LOCAL_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Fieldbus side requests
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_index,
  input wire logic [7:0] i_req_sub,
  input wire logic [31:0] i_req_data,
  input wire logic i_req_block_store,
  output logic o_rsp_valid,
  output logic o_rsp_ok,
  output logic [31:0] o_rsp_data,
  output logic o_overflow,
  // Link to main controller
  output logic o_pd_slot,
  input wire logic i_pd_valid,
  input wire logic [31:0] i_pd_position,
  input wire logic [15:0] i_pd_status,
  input wire logic [15:0] i_pd_error,
  output logic o_sd_valid,
  output logic [15:0] o_sd_index,
  output logic [7:0] o_sd_sub,
  output logic [31:0] o_sd_data,
  output logic [31:0] o_position,
  output logic [15:0] o_status,
  output logic [15:0] o_error,
  // Nonvolatile store commands
  output logic o_nv_byte_commit,
  output logic o_nv_block_commit,
  output logic o_nv_byte_restore,
  output logic o_nv_block_restore,
  output logic o_nv_block_reload
);
  localparam int unsigned PW = $clog2(FIFO_DEPTH);
  localparam int unsigned CW = $clog2(CYCLE_CLKS);
  localparam int unsigned LW = $clog2(LOCAL_DEPTH);
  localparam logic [PW-1:0] LAST = PW'(FIFO_DEPTH - 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYCLE_CLKS - 1);
  localparam logic [CW-1:0] GAP_AT = CW'(CYCLE_CLKS / 2);

  // ==========================================================
  // Storage
  logic [sdfb_pkg::ENTRY_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [31:0] local_mem [LOCAL_DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr;
  logic [PW-1:0] rd_ptr, next_rd_ptr;
  logic [PW:0] count, next_count;
  logic [CW-1:0] tick, next_tick;
  sdfb_pkg::sdfb_slot_t slot, next_slot;
  logic sd_sent, next_sd_sent;
  logic rsp_valid, next_rsp_valid;
  logic rsp_ok, next_rsp_ok;
  logic [31:0] rsp_data, next_rsp_data;
  logic overflow, next_overflow;
  logic pd_slot, next_pd_slot;
  logic sd_valid, next_sd_valid;
  logic [sdfb_pkg::ENTRY_W-1:0] sd_entry, next_sd_entry;
  logic [31:0] position, next_position;
  logic [15:0] status, next_status;
  logic [15:0] error, next_error;
  logic nv_bc, next_nv_bc, nv_kc, next_nv_kc, nv_br, next_nv_br, nv_kr, next_nv_kr;
  logic nv_reload, next_nv_reload;
  logic dirty, next_dirty;
  logic push, pop, full;
  logic [LW-1:0] slot_of_req;

  // Local slot selected from low bits of index XOR subindex, full 16-bit index kept in queue
  assign slot_of_req = LW'(i_req_index ^ {8'h00, i_req_sub});
  assign full = (count == (PW+1)'(FIFO_DEPTH));
  assign push = i_req_valid && i_req_write && !full;
  assign pop = (slot == sdfb_pkg::SL_GAP) && !sd_sent && (count != '0);

  // ==========================================================
  // Queue pointers, cycle timer and answers
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_tick = (tick == CYC_LAST) ? '0 : tick + CW'(1);
    next_slot = slot;
    next_sd_sent = sd_sent;
    next_rsp_valid = 1'b0;
    next_rsp_ok = 1'b0;
    next_rsp_data = rsp_data;
    next_overflow = overflow;
    next_pd_slot = 1'b0;
    next_sd_valid = 1'b0;
    next_sd_entry = sd_entry;
    next_position = position;
    next_status = status;
    next_error = error;
    next_nv_bc = 1'b0;
    next_nv_kc = 1'b0;
    next_nv_br = 1'b0;
    next_nv_kr = 1'b0;
    next_nv_reload = 1'b0;
    next_dirty = dirty;
    // Exchange slot sequence within each cycle
    case (slot)
      sdfb_pkg::SL_IDLE: begin
        // Timer starts with the first frame so the first cycle is full length
        next_tick = '0;
        next_slot = sdfb_pkg::SL_PD;
        next_pd_slot = 1'b1;
      end
      sdfb_pkg::SL_PD: begin
        if (i_pd_valid) begin
          next_position = i_pd_position;
          next_status = i_pd_status;
          next_error = i_pd_error;
        end
        if (tick == GAP_AT) begin
          next_slot = sdfb_pkg::SL_GAP;
        end
      end
      sdfb_pkg::SL_GAP: begin
        if (pop) begin
          next_sd_valid = 1'b1;
          next_sd_entry = fifo_mem[rd_ptr];
          next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
          next_sd_sent = 1'b1;
        end
        next_slot = sdfb_pkg::SL_SD;
      end
      sdfb_pkg::SL_SD: begin
        if (tick == CYC_LAST) begin
          next_slot = sdfb_pkg::SL_PD;
          next_pd_slot = 1'b1;
          next_sd_sent = 1'b0;
        end
      end
      default: begin
        next_slot = sdfb_pkg::SL_IDLE;
      end
    endcase
    // Ring queue bookkeeping
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
    end
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
    // Overflow sticks until a write is accepted again
    if (i_req_valid && i_req_write && full) begin
      next_overflow = 1'b1;
    end else if (push) begin
      next_overflow = 1'b0;
    end
    // Answers come from local copy at once
    if (i_req_valid) begin
      next_rsp_valid = 1'b1;
      next_rsp_ok = !i_req_write || !full;
      next_rsp_data = i_req_write ? i_req_data : local_mem[slot_of_req];
      if (push) begin
        if (i_req_index == sdfb_pkg::IDX_SAVE) begin
          next_nv_kc = dirty;
          next_dirty = 1'b0;
        end else if (i_req_index == sdfb_pkg::IDX_RESTORE_BLOCK) begin
          next_nv_kr = 1'b1;
          next_dirty = 1'b1;
        end else if (i_req_index == sdfb_pkg::IDX_RESTORE_BYTE) begin
          next_nv_br = 1'b1;
        end else if (i_req_block_store) begin
          next_dirty = 1'b1;
        end else begin
          next_nv_bc = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Register the control state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      tick <= '0;
      slot <= sdfb_pkg::SL_IDLE;
      sd_sent <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_data <= sdfb_pkg::DATA_RST;
      overflow <= 1'b0;
      pd_slot <= 1'b0;
      sd_valid <= 1'b0;
      sd_entry <= '0;
      position <= sdfb_pkg::DATA_RST;
      status <= 16'h0000;
      error <= 16'h0000;
      nv_bc <= 1'b0;
      nv_kc <= 1'b0;
      nv_br <= 1'b0;
      nv_kr <= 1'b0;
      nv_reload <= 1'b1;
      dirty <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      tick <= next_tick;
      slot <= next_slot;
      sd_sent <= next_sd_sent;
      rsp_valid <= next_rsp_valid;
      rsp_ok <= next_rsp_ok;
      rsp_data <= next_rsp_data;
      overflow <= next_overflow;
      pd_slot <= next_pd_slot;
      sd_valid <= next_sd_valid;
      sd_entry <= next_sd_entry;
      position <= next_position;
      status <= next_status;
      error <= next_error;
      nv_bc <= next_nv_bc;
      nv_kc <= next_nv_kc;
      nv_br <= next_nv_br;
      nv_kr <= next_nv_kr;
      nv_reload <= next_nv_reload;
      dirty <= next_dirty;
    end
  end

  // ==========================================================
  // Queue and local value arrays, no reset
  always_ff @(posedge i_clk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= {i_req_index, i_req_sub, i_req_data};
    end
    if (i_req_valid && i_req_write) begin
      local_mem[slot_of_req] <= i_req_data;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rsp_valid = rsp_valid;
  assign o_rsp_ok = rsp_ok;
  assign o_rsp_data = rsp_data;
  assign o_overflow = overflow;
  assign o_pd_slot = pd_slot;
  assign o_sd_valid = sd_valid;
  assign o_sd_index = sd_entry[sdfb_pkg::ENTRY_W-1 -: 16];
  assign o_sd_sub = sd_entry[sdfb_pkg::DATA_W +: 8];
  assign o_sd_data = sd_entry[sdfb_pkg::DATA_W-1:0];
  assign o_position = position;
  assign o_status = status;
  assign o_error = error;
  assign o_nv_byte_commit = nv_bc;
  assign o_nv_block_commit = nv_kc;
  assign o_nv_byte_restore = nv_br;
  assign o_nv_block_restore = nv_kr;
  assign o_nv_block_reload = nv_reload;
endmodule : sdfb_bridge

// ==== dv/sdfb_monitor.sv ====
// Port checker of the bridge.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module sdfb_monitor #(
  parameter int unsigned CYCLE_CLKS = 100
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [15:0] i_req_index,
  input wire logic i_req_block_store,
  input wire logic o_rsp_valid,
  input wire logic o_rsp_ok,
  input wire logic o_overflow,
  input wire logic o_pd_slot,
  input wire logic o_sd_valid,
  input wire logic o_nv_byte_commit,
  input wire logic o_nv_block_commit,
  input wire logic o_nv_byte_restore,
  input wire logic o_nv_block_restore
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [31:0] gap;
  logic seen;
  logic sd_done;
  // ==========================================================
  // Cycle length and forwards per cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap <= 32'h0;
      seen <= 1'b0;
      sd_done <= 1'b0;
    end else begin
      gap <= o_pd_slot ? 32'h1 : gap + 32'h1;
      seen <= seen | o_pd_slot;
      sd_done <= o_pd_slot ? 1'b0 : (sd_done | o_sd_valid);
    end
  end
  // ==========================================================
  // Request steps
  sequence wr_taken(logic [15:0] idx);
    i_req_valid && i_req_write && i_req_index == idx;
  endsequence
  sequence answered_ok;
    o_rsp_valid && o_rsp_ok;
  endsequence
  rsp_timing_a: assert property (i_req_valid |=> o_rsp_valid) else $error("answer missing");
  rsp_cause_a: assert property (o_rsp_valid |-> $past(i_req_valid)) else $error("stray answer");
  byte_commit_a: assert property (
    wr_taken(16'h2020) ##0 !i_req_block_store ##1 answered_ok |-> o_nv_byte_commit)
    else $error("byte commit missing");
  save_only_a: assert property (
    o_nv_block_commit |-> $past(i_req_valid && i_req_write && i_req_index == 16'h1010))
    else $error("block commit without save");
  byte_restore_a: assert property (wr_taken(16'h2015) ##1 answered_ok |-> o_nv_byte_restore)
    else $error("byte restore missing");
  block_restore_a: assert property (wr_taken(16'h1011) ##1 answered_ok |-> o_nv_block_restore)
    else $error("block restore missing");
  cycle_len_a: assert property (o_pd_slot && seen |-> gap == CYCLE_CLKS) else $error("cycle length wrong");
  one_fwd_a: assert property (o_sd_valid |-> !sd_done) else $error("second forward in cycle");
  ovf_rise_a: assert property ($rose(o_overflow) |-> o_rsp_valid && !o_rsp_ok) else $error("overflow cause");
  refuse_flag_a: assert property (o_rsp_valid && !o_rsp_ok |-> o_overflow) else $error("refusal unflagged");
endmodule : sdfb_monitor

bind sdfb_bridge sdfb_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) sdfb_monitor_i (.*);

// ==== dv/sdfb_main_model.sv ====
// Main controller model on the link.
// Assumes slot and forward pulses on i_clk.
`timescale 1ns/100ps
module sdfb_main_model #(
  parameter int unsigned DELAY = 3
) (
  input wire logic i_clk,
  input wire logic i_pd_slot,
  input wire logic i_sd_valid,
  input wire logic [7:0] i_sd_sub,
  output logic o_pd_valid,
  output logic [31:0] o_pd_position,
  output logic [15:0] o_pd_status,
  output logic [15:0] o_pd_error
);
  logic [7:0] got [0:15];
  int n_got = 0;
  int wait_c = 0;
  logic [31:0] pos = 32'h0000_1000;
  initial begin
    o_pd_valid = 1'b0;
    o_pd_position = 32'h0;
    o_pd_status = 16'h0;
    o_pd_error = 16'h0;
  end
  // One frame per cycle, fields scrambled outside it
  always @(posedge i_clk) begin
    wait_c <= i_pd_slot ? DELAY : (wait_c > 0 ? wait_c - 1 : 0);
    o_pd_valid <= (wait_c == 1);
    if (wait_c == 1) begin
      o_pd_position <= pos;
      o_pd_status <= pos[15:0];
      o_pd_error <= ~pos[15:0];
      pos <= pos + 32'h1;
    end else begin
      o_pd_position <= ~o_pd_position;
      o_pd_status <= ~o_pd_status;
      o_pd_error <= ~o_pd_error;
    end
    // Record forwarded commands
    if (i_sd_valid) begin
      got[n_got[3:0]] <= i_sd_sub;
      n_got <= n_got + 1;
    end
  end
endmodule : sdfb_main_model

// ==== dv/sdfb_bridge_test.sv ====
// Testbench of the bridge with a main controller model.
// Assumes the checker is bound to the design.
`timescale 1ns/100ps
module sdfb_bridge_test;
  localparam int unsigned CYC = 100;
  localparam int unsigned DEPTH = 8;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_req_valid = 1'b0, i_req_write = 1'b0, i_req_block_store = 1'b0;
  logic [15:0] i_req_index = 16'h0;
  logic [7:0] i_req_sub = 8'h0;
  logic [31:0] i_req_data = 32'h0;
  logic o_rsp_valid, o_rsp_ok, o_overflow, o_pd_slot, i_pd_valid, o_sd_valid, o_nv_block_reload;
  logic o_nv_byte_commit, o_nv_block_commit, o_nv_byte_restore, o_nv_block_restore;
  logic [31:0] o_rsp_data, i_pd_position, o_sd_data, o_position;
  logic [15:0] i_pd_status, i_pd_error, o_sd_index, o_status, o_error;
  logic [7:0] o_sd_sub;
  int miscompares = 0;
  int checks_done = 0;
  sdfb_bridge #(.CYCLE_CLKS(CYC), .FIFO_DEPTH(DEPTH)) sdfb_bridge_i (.*);
  sdfb_main_model sdfb_main_model_i (.i_clk(i_clk), .i_pd_slot(o_pd_slot), .i_sd_valid(o_sd_valid),
    .i_sd_sub(o_sd_sub), .o_pd_valid(i_pd_valid), .o_pd_position(i_pd_position),
    .o_pd_status(i_pd_status), .o_pd_error(i_pd_error));
  always #10 i_clk = ~i_clk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : cmp
  task automatic req(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
    input logic blk);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req_write <= w;
    i_req_index <= idx;
    i_req_sub <= sub;
    i_req_data <= d;
    i_req_block_store <= blk;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    #1;
  endtask : req
  // Fill past full, then watch the drain order
  task automatic t_fifo;
    @(posedge o_pd_slot);
    for (int k = 0; k <= DEPTH; k++) begin
      req(1'b1, 16'h2020, k[7:0], 32'h100 + k, 1'b0);
      if (k == 0) cmp(o_nv_block_reload, 1'b0, "reload after reset");
      cmp(o_rsp_ok, k < DEPTH, "accept");
      cmp(o_nv_byte_commit, k < DEPTH, "byte commit");
    end
    cmp(o_overflow, 1'b1, "overflow");
    repeat ((DEPTH + 2) * CYC) @(posedge i_clk);
    cmp(sdfb_main_model_i.n_got, DEPTH, "forward count");
    for (int k = 0; k < DEPTH; k++) cmp(sdfb_main_model_i.got[k], k, "forward order");
    cmp(o_sd_index, 16'h2020, "forward index");
    cmp(o_sd_data, 32'h100 + DEPTH - 1, "forward data");
  endtask : t_fifo
  // Store commands and their nonvolatile actions
  task automatic t_store;
    logic [15:0] idx_t [6] = '{16'h2020, 16'h2020, 16'h1010, 16'h1010, 16'h2015, 16'h1011};
    logic [3:0] exp_t [6] = '{4'h8, 4'h0, 4'h4, 4'h0, 4'h2, 4'h1};
    for (int k = 0; k < 6; k++) begin
      req(1'b1, idx_t[k], 8'h00, 32'ha00 + k, k == 1);
      cmp({o_nv_byte_commit, o_nv_block_commit, o_nv_byte_restore, o_nv_block_restore}, exp_t[k], "nv");
      if (k == 0) cmp(o_overflow, 1'b0, "overflow clear");
    end
  endtask : t_store
  // Immediate reads and process frame copy
  task automatic t_read;
    logic [31:0] p;
    req(1'b0, 16'h2020, 8'h03, 32'h0, 1'b0);
    cmp(o_rsp_data, 32'h103, "read back");
    req(1'b0, 16'h2020, 8'h08, 32'h0, 1'b0);
    cmp(o_rsp_data, 32'h108, "refused value kept");
    @(posedge o_pd_slot);
    repeat (10) @(posedge i_clk);
    p = sdfb_main_model_i.pos - 32'h1;
    cmp(o_position, p, "position");
    cmp(o_status, {16'h0000, p[15:0]}, "status");
    cmp(o_error, {16'h0000, ~p[15:0]}, "error");
  endtask : t_read
  task automatic summarize;
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    cmp(o_nv_block_reload, 1'b1, "reload in reset");
    i_arst_n <= 1'b1;
    t_fifo();
    t_store();
    t_read();
    summarize();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    $display("BAD %0t timeout", $time);
    summarize();
  end
endmodule : sdfb_bridge_test
